/* bgp_params.svh */
`ifndef BGP_PARAMS_SVH
`define BGP_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define BGP_ADDR_W         8
`define BGP_PORT_W         8

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define BGP_THIRD_DATA_OFF    8'h00
`define BGP_THIRD_DIR_OFF     8'h04
`define BGP_FOURTH_DATA_OFF   8'h08
`define BGP_FOURTH_DIR_OFF    8'h0C
`define BGP_THIRD_ANALOG_OFF  8'h10
`define BGP_FOURTH_ANALOG_OFF 8'h14
`define BGP_THIRD_SET_OFF     8'h18
`define BGP_THIRD_CLR_OFF     8'h1C
`define BGP_FOURTH_SET_OFF    8'h20
`define BGP_FOURTH_CLR_OFF    8'h24
`define BGP_CONTROL_OFF       8'h28

// ----------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------
`define BGP_CTRL_LP_BIT    0
`define BGP_CTRL_SRST_BIT  1
`define BGP_DIR_RST        8'hFF
`define BGP_DATA_POR       8'h00
`define BGP_ANALOG_RST     8'h00
`define BGP_LP_RST         1'h0
`define BGP_RESP_OKAY      2'h0
`define BGP_RESP_SLVERR    2'h2

`endif

/* bgp_pkg.sv */
`default_nettype none
`include "bgp_params.svh"

package bgp_pkg;
	// one port's worth of pins or register bits
	typedef logic [`BGP_PORT_W-1:0] bgp_byte_type;
	// register bus address
	typedef logic [`BGP_ADDR_W-1:0] bgp_addr_type;
	// how a latch write merges with the live pins
	typedef enum logic [1:0] {
		BGP_WR_LOAD,
		BGP_WR_SET,
		BGP_WR_CLEAR
	} bgp_wop_type;
endpackage : bgp_pkg

`default_nettype wire

/* bgp_port_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface bgp_port_if;
	import bgp_pkg::*;
	// write side
	logic         wrLatch;
	bgp_wop_type  latchOp;
	logic         wrDir;
	logic         wrAnalog;
	logic         dirReset;
	bgp_byte_type wrData;
	// read side
	bgp_byte_type rdPins;
	bgp_byte_type rdDir;
	bgp_byte_type rdAnalog;

	modport ctrl (
		output wrLatch, latchOp, wrDir, wrAnalog, dirReset, wrData,
		input  rdPins, rdDir, rdAnalog
	);
	modport port (
		input  wrLatch, latchOp, wrDir, wrAnalog, dirReset, wrData,
		output rdPins, rdDir, rdAnalog
	);
endinterface : bgp_port_if

`default_nettype wire

/* bgp_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bgp_params.svh"

module bgp_port (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	// pins
	input  wire bgp_pkg::bgp_byte_type pinIn,
	output wire bgp_pkg::bgp_byte_type pinOut,
	output wire bgp_pkg::bgp_byte_type pinOe_n,
	// register side
	bgp_port_if.port                   regs
);
	import bgp_pkg::*;

	bgp_byte_type syncFirst;
	bgp_byte_type syncSecond;
	bgp_byte_type latch;
	bgp_byte_type direction;
	bgp_byte_type analog;
	bgp_byte_type next_latch;

	// ----------------------------------------------------------------
	// merge of modification into sampled pins
	// ----------------------------------------------------------------
	function automatic bgp_byte_type merge_bits(input bgp_wop_type op,
		input bgp_byte_type live, input bgp_byte_type mods);
		case (op)
			BGP_WR_SET:   merge_bits = live | mods;
			BGP_WR_CLEAR: merge_bits = live & ~mods;
			default:      merge_bits = mods;
		endcase
	endfunction : merge_bits

	// two-flop pin synchroniser, digital threshold taken at pad
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			syncFirst  <= 8'h00;
			syncSecond <= 8'h00;
		end else begin
			syncFirst  <= pinIn;
			syncSecond <= syncFirst;
		end
	end

	// live levels, analog pins forced low
	assign regs.rdPins   = syncSecond & ~analog;
	assign regs.rdDir    = direction;
	assign regs.rdAnalog = analog;
	assign next_latch    = merge_bits(regs.latchOp, regs.rdPins, regs.wrData);

	// output latch, soft reset leaves it alone
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			latch <= `BGP_DATA_POR;
		end else if (regs.wrLatch) begin
			latch <= next_latch;
		end
	end

	// direction and analog select
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			direction <= `BGP_DIR_RST;
			analog    <= `BGP_ANALOG_RST;
		end else begin
			if (regs.dirReset) begin
				direction <= `BGP_DIR_RST;
			end else if (regs.wrDir) begin
				direction <= regs.wrData;
			end
			if (regs.wrAnalog) begin
				analog <= regs.wrData;
			end
		end
	end

	// per-pin driver: one means high impedance, zero drives latch
	assign pinOe_n = direction;
	assign pinOut  = latch;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence pinsSettled;
		$past(rst_n) && $past(rst_n, 2);
	endsequence
	sequence loadOut;
		regs.wrLatch && regs.latchOp == BGP_WR_LOAD && direction == 8'h00 && !regs.wrDir
			&& !regs.dirReset;
	endsequence

	read_live_a: assert property (pinsSettled |-> regs.rdPins == ($past(pinIn, 2) & ~analog))
		else $error("port read does not follow synchronised pins");
	analog_zero_a: assert property (regs.wrAnalog ##1 1'b1 |-> (regs.rdPins & $past(regs.wrData)) == 8'h00)
		else $error("analog pin reads nonzero");
	dir_load_a: assert property (regs.wrDir && !regs.dirReset |=> pinOe_n == $past(regs.wrData))
		else $error("direction write not seen on output enables");
	drive_latch_a: assert property (loadOut |=> pinOut == $past(regs.wrData) && pinOe_n == 8'h00)
		else $error("driven pin does not show written latch");
	rmw_set_a: assert property (regs.wrLatch && regs.latchOp == BGP_WR_SET
		|=> latch == ($past(regs.rdPins) | $past(regs.wrData)))
		else $error("bit set did not merge with live pins");
	rmw_clear_a: assert property (regs.wrLatch && regs.latchOp == BGP_WR_CLEAR
		|=> latch == ($past(regs.rdPins) & ~$past(regs.wrData)))
		else $error("bit clear did not merge with live pins");
	soft_reset_a: assert property (regs.dirReset && !regs.wrLatch
		|=> pinOe_n == 8'hFF && $stable(latch))
		else $error("soft reset wrong on direction or latch");
endmodule : bgp_port

`default_nettype wire

/* bgp_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bgp_params.svh"

module bgp_top (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	// axi4-lite write address
	input  wire logic                  s_axi_awvalid,
	output wire logic                  s_axi_awready,
	input  wire bgp_pkg::bgp_addr_type s_axi_awaddr,
	// axi4-lite write data
	input  wire logic                  s_axi_wvalid,
	output wire logic                  s_axi_wready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	// axi4-lite write response
	output wire logic                  s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	output wire logic [1:0]            s_axi_bresp,
	// axi4-lite read address
	input  wire logic                  s_axi_arvalid,
	output wire logic                  s_axi_arready,
	input  wire bgp_pkg::bgp_addr_type s_axi_araddr,
	// axi4-lite read data
	output wire logic                  s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output wire logic [31:0]           s_axi_rdata,
	output wire logic [1:0]            s_axi_rresp,
	// third port pins
	input  wire bgp_pkg::bgp_byte_type thirdPinIn,
	output wire bgp_pkg::bgp_byte_type thirdPinOut,
	output wire bgp_pkg::bgp_byte_type thirdPinOe_n,
	// fourth port pins
	input  wire bgp_pkg::bgp_byte_type fourthPinIn,
	output wire bgp_pkg::bgp_byte_type fourthPinOut,
	output wire bgp_pkg::bgp_byte_type fourthPinOe_n
);
	import bgp_pkg::*;

	// ----------------------------------------------------------------
	// address match on word index
	// ----------------------------------------------------------------
	function automatic logic hit(input bgp_addr_type addr, input bgp_addr_type off);
		hit = (addr[`BGP_ADDR_W-1:2] == off[`BGP_ADDR_W-1:2]);
	endfunction : hit

	bgp_port_if thirdRegs ();
	bgp_port_if fourthRegs ();

	// write channel holding
	logic         awHeld;
	bgp_addr_type awAddr;
	logic         wHeld;
	logic [7:0]   wByte;
	logic         wLane;
	logic         bValid;
	logic [1:0]   bResp;
	// read channel
	logic         rValid;
	logic [31:0]  rData;
	logic [1:0]   rResp;
	// control state
	logic         lowPowerCrystalMode;

	// ----------------------------------------------------------------
	// write path
	// ----------------------------------------------------------------
	// address and data are caught independently, in either order
	assign s_axi_awready = !awHeld;
	assign s_axi_wready  = !wHeld;
	assign s_axi_bvalid  = bValid;
	assign s_axi_bresp   = bResp;

	wire doWrite = awHeld && wHeld && !bValid;
	wire wrEn    = doWrite && wLane;

	// write-address decode
	wire wHitThirdData    = hit(awAddr, `BGP_THIRD_DATA_OFF);
	wire wHitThirdDir     = hit(awAddr, `BGP_THIRD_DIR_OFF);
	wire wHitFourthData   = hit(awAddr, `BGP_FOURTH_DATA_OFF);
	wire wHitFourthDir    = hit(awAddr, `BGP_FOURTH_DIR_OFF);
	wire wHitThirdAnalog  = hit(awAddr, `BGP_THIRD_ANALOG_OFF);
	wire wHitFourthAnalog = hit(awAddr, `BGP_FOURTH_ANALOG_OFF);
	wire wHitThirdSet     = hit(awAddr, `BGP_THIRD_SET_OFF);
	wire wHitThirdClr     = hit(awAddr, `BGP_THIRD_CLR_OFF);
	wire wHitFourthSet    = hit(awAddr, `BGP_FOURTH_SET_OFF);
	wire wHitFourthClr    = hit(awAddr, `BGP_FOURTH_CLR_OFF);
	wire wHitControl      = hit(awAddr, `BGP_CONTROL_OFF);
	wire wMapped = wHitThirdData | wHitThirdDir | wHitFourthData | wHitFourthDir
		| wHitThirdAnalog | wHitFourthAnalog | wHitThirdSet | wHitThirdClr
		| wHitFourthSet | wHitFourthClr | wHitControl;
	wire softReset = wrEn && wHitControl && wByte[`BGP_CTRL_SRST_BIT];

	// third port strobes
	assign thirdRegs.wrLatch  = wrEn && (wHitThirdData || wHitThirdSet || wHitThirdClr);
	assign thirdRegs.latchOp  = wHitThirdSet ? BGP_WR_SET :
		(wHitThirdClr ? BGP_WR_CLEAR : BGP_WR_LOAD);
	assign thirdRegs.wrDir    = wrEn && wHitThirdDir;
	assign thirdRegs.wrAnalog = wrEn && wHitThirdAnalog;
	assign thirdRegs.dirReset = softReset;
	assign thirdRegs.wrData   = wByte;

	// fourth port strobes, bits 4:0 carry no alternate function
	assign fourthRegs.wrLatch  = wrEn && (wHitFourthData || wHitFourthSet || wHitFourthClr);
	assign fourthRegs.latchOp  = wHitFourthSet ? BGP_WR_SET :
		(wHitFourthClr ? BGP_WR_CLEAR : BGP_WR_LOAD);
	assign fourthRegs.wrDir    = wrEn && wHitFourthDir;
	assign fourthRegs.wrAnalog = wrEn && wHitFourthAnalog;
	assign fourthRegs.dirReset = softReset;
	assign fourthRegs.wrData   = wByte;

	// address holding register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			awHeld <= 1'b0;
			awAddr <= 8'h00;
		end else if (s_axi_awvalid && !awHeld) begin
			awHeld <= 1'b1;
			awAddr <= s_axi_awaddr;
		end else if (doWrite) begin
			awHeld <= 1'b0;
		end
	end

	// data holding register, only the low byte lane matters
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wHeld <= 1'b0;
			wByte <= 8'h00;
			wLane <= 1'b0;
		end else if (s_axi_wvalid && !wHeld) begin
			wHeld <= 1'b1;
			wByte <= s_axi_wdata[7:0];
			wLane <= s_axi_wstrb[0];
		end else if (doWrite) begin
			wHeld <= 1'b0;
		end
	end

	// write response
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bValid <= 1'b0;
			bResp  <= `BGP_RESP_OKAY;
		end else if (doWrite) begin
			bValid <= 1'b1;
			bResp  <= wMapped ? `BGP_RESP_OKAY : `BGP_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bValid <= 1'b0;
		end
	end

	// control register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lowPowerCrystalMode <= `BGP_LP_RST;
		end else if (wrEn && wHitControl) begin
			lowPowerCrystalMode <= wByte[`BGP_CTRL_LP_BIT];
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	assign s_axi_arready = !rValid;
	assign s_axi_rvalid  = rValid;
	assign s_axi_rdata   = rData;
	assign s_axi_rresp   = rResp;

	// read-address decode
	wire rHitThirdData    = hit(s_axi_araddr, `BGP_THIRD_DATA_OFF);
	wire rHitThirdDir     = hit(s_axi_araddr, `BGP_THIRD_DIR_OFF);
	wire rHitFourthData   = hit(s_axi_araddr, `BGP_FOURTH_DATA_OFF);
	wire rHitFourthDir    = hit(s_axi_araddr, `BGP_FOURTH_DIR_OFF);
	wire rHitThirdAnalog  = hit(s_axi_araddr, `BGP_THIRD_ANALOG_OFF);
	wire rHitFourthAnalog = hit(s_axi_araddr, `BGP_FOURTH_ANALOG_OFF);
	wire rHitWriteOnly    = hit(s_axi_araddr, `BGP_THIRD_SET_OFF)
		| hit(s_axi_araddr, `BGP_THIRD_CLR_OFF)
		| hit(s_axi_araddr, `BGP_FOURTH_SET_OFF)
		| hit(s_axi_araddr, `BGP_FOURTH_CLR_OFF);
	wire rHitControl      = hit(s_axi_araddr, `BGP_CONTROL_OFF);
	wire rMapped = rHitThirdData | rHitThirdDir | rHitFourthData | rHitFourthDir
		| rHitThirdAnalog | rHitFourthAnalog | rHitWriteOnly | rHitControl;

	// low-power crystal mode forces the two lowest direction bits high
	wire bgp_byte_type thirdDirRead = thirdRegs.rdDir
		| {6'h00, {2{lowPowerCrystalMode}}};
	wire bgp_byte_type controlRead  = {7'h00, lowPowerCrystalMode};

	// read data select, pin levels rather than latch
	wire bgp_byte_type readMux =
		rHitThirdData    ? thirdRegs.rdPins :
		rHitThirdDir     ? thirdDirRead :
		rHitFourthData   ? fourthRegs.rdPins :
		rHitFourthDir    ? fourthRegs.rdDir :
		rHitThirdAnalog  ? thirdRegs.rdAnalog :
		rHitFourthAnalog ? fourthRegs.rdAnalog :
		rHitControl      ? controlRead : 8'h00;

	// read response register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rValid <= 1'b0;
			rData  <= 32'h00000000;
			rResp  <= `BGP_RESP_OKAY;
		end else if (s_axi_arvalid && !rValid) begin
			rValid <= 1'b1;
			rData  <= {24'h000000, readMux};
			rResp  <= rMapped ? `BGP_RESP_OKAY : `BGP_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rValid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// port instances
	// ----------------------------------------------------------------
	// third port, all eight pins bidirectional
	bgp_port u_third (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pinIn   (thirdPinIn),
		.pinOut  (thirdPinOut),
		.pinOe_n (thirdPinOe_n),
		.regs    (thirdRegs.port)
	);

	// fourth port, same pin logic
	bgp_port u_fourth (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pinIn   (fourthPinIn),
		.pinOut  (fourthPinOut),
		.pinOe_n (fourthPinOe_n),
		.regs    (fourthRegs.port)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence bothTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !bValid;
	endsequence
	sequence readTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	lp_read_a: assert property (readTaken and (lowPowerCrystalMode && rHitThirdDir)
		|=> s_axi_rdata[1:0] == 2'h3)
		else $error("low direction bits not forced in low-power mode");
	dir_read_a: assert property (readTaken and (!lowPowerCrystalMode && rHitThirdDir)
		|=> s_axi_rdata == {24'h000000, $past(thirdRegs.rdDir)})
		else $error("third direction read wrong");
	write_resp_a: assert property (bothTaken |-> !s_axi_bvalid ##1 doWrite ##1 s_axi_bvalid)
		else $error("write response not two cycles after handshake");
	read_resp_a: assert property (readTaken |=> s_axi_rvalid
		&& s_axi_rdata == {24'h000000, $past(readMux)})
		else $error("read response missing or wrong");
	fourth_read_a: assert property (readTaken and rHitFourthData
		|=> s_axi_rdata[7:0] == $past(fourthRegs.rdPins))
		else $error("fourth port read not from pins");
	unmapped_err_a: assert property (readTaken and !rMapped
		|=> s_axi_rresp == `BGP_RESP_SLVERR && s_axi_rdata == 32'h00000000)
		else $error("unmapped read not refused");
	hold_resp_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");

	// ----------------------------------------------------------------
	// refusals, byte lane, read framing and pin drivers
	// ----------------------------------------------------------------
	// unmapped write touches no register and answers slave error
	bad_write_a: assert property (doWrite && !wMapped
		|-> (!thirdRegs.wrLatch && !fourthRegs.wrLatch && !thirdRegs.wrDir && !fourthRegs.wrDir)
		##1 s_axi_bresp == `BGP_RESP_SLVERR)
		else $error("unmapped write was not refused");
	// a write with the low byte lane off changes nothing
	lane_off_a: assert property (doWrite && !wLane |-> !thirdRegs.wrLatch && !fourthRegs.wrLatch
		&& !thirdRegs.wrDir && !fourthRegs.wrDir && !softReset)
		else $error("write without low lane took effect");
	// only eight pins exist, upper read bits stay zero
	upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	// third port read comes from the synchronised pins
	third_read_a: assert property (readTaken and rHitThirdData
		|=> s_axi_rdata[7:0] == $past(thirdRegs.rdPins))
		else $error("third port read not from pins");
	// bit-set and bit-clear places read back as zero
	set_read_a: assert property (readTaken and rHitWriteOnly
		|=> s_axi_rdata == 32'h00000000 && s_axi_rresp == `BGP_RESP_OKAY)
		else $error("set or clear place read nonzero");
	// low-power mode alters reads only, never the drivers
	lp_drive_a: assert property (lowPowerCrystalMode |-> thirdPinOe_n == thirdRegs.rdDir)
		else $error("low-power mode changed third drivers");
	// analog select leaves the output enables to direction
	analog_drive_a: assert property (thirdRegs.rdAnalog != 8'h00
		|-> thirdPinOe_n == thirdRegs.rdDir)
		else $error("analog select changed third drivers");
endmodule : bgp_top

`default_nettype wire

/* bgp_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none

module bgp_pin_model (
	// device side of the pads
	input  wire bgp_pkg::bgp_byte_type pinOut,
	input  wire bgp_pkg::bgp_byte_type pinOe_n,
	// level forced by the board
	input  wire bgp_pkg::bgp_byte_type extLevel,
	// resolved pad level back to the device
	output wire bgp_pkg::bgp_byte_type pinIn
);
	import bgp_pkg::*;
	// ------------------------------------------------
	// pad resolution
	// ------------------------------------------------
	// board drives only where the device has let go
	assign pinIn = (pinOut & ~pinOe_n) | (extLevel & pinOe_n);
endmodule : bgp_pin_model

`default_nettype wire

/* bgp_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bgp_params.svh"
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin errors++; \
$display("BAD %s expected %h seen %h", nm, ex, got); end end

module bgp_top_tb_top;
	import bgp_pkg::*;
	logic         clk_sys = 1'b0;
	logic         rst_n = 1'b0;
	logic         s_axi_awvalid = 1'b0;
	logic         s_axi_wvalid = 1'b0;
	logic         s_axi_bready = 1'b0;
	logic         s_axi_arvalid = 1'b0;
	logic         s_axi_rready = 1'b0;
	bgp_addr_type s_axi_awaddr = 8'h00;
	bgp_addr_type s_axi_araddr = 8'h00;
	logic [31:0]  s_axi_wdata = 32'h00000000;
	logic [3:0]   s_axi_wstrb = 4'hF;
	wire          s_axi_awready;
	wire          s_axi_wready;
	wire          s_axi_bvalid;
	wire          s_axi_arready;
	wire          s_axi_rvalid;
	wire [1:0]    s_axi_bresp;
	wire [1:0]    s_axi_rresp;
	wire [31:0]   s_axi_rdata;
	bgp_byte_type extThird = 8'hA5;
	bgp_byte_type extFourth = 8'h3C;
	wire bgp_byte_type thirdIn, thirdOut, thirdOe_n, fourthIn, fourthOut, fourthOe_n;
	int           errors = 0;
	int           totalChecks = 0;
	logic [31:0]  rd;
	logic [1:0]   rsp;

	// ------------------------------------------------
	// clock, design and pads
	// ------------------------------------------------
	always #12.5 clk_sys = ~clk_sys;

	bgp_top DUT (.clk_sys(clk_sys), .rst_n(rst_n),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.thirdPinIn(thirdIn), .thirdPinOut(thirdOut), .thirdPinOe_n(thirdOe_n),
		.fourthPinIn(fourthIn), .fourthPinOut(fourthOut), .fourthPinOe_n(fourthOe_n));
	bgp_pin_model thirdPads (.pinOut(thirdOut), .pinOe_n(thirdOe_n),
		.extLevel(extThird), .pinIn(thirdIn));
	bgp_pin_model fourthPads (.pinOut(fourthOut), .pinOe_n(fourthOe_n),
		.extLevel(extFourth), .pinIn(fourthIn));

	// ------------------------------------------------
	// bus tasks
	// ------------------------------------------------
	// write: address and data together, each dropped once taken;
	// bready rises only once bvalid is seen, so the slave must hold it
	task automatic axWrite(input bgp_addr_type a, input bgp_byte_type d, output logic [1:0] r);
		logic awDone;
		logic wDone;
		awDone = 1'b0;
		wDone = 1'b0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(awDone && wDone)) begin
			@(posedge clk_sys);
			if (!awDone && s_axi_awready === 1'b1) begin
				awDone = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wDone && s_axi_wready === 1'b1) begin
				wDone = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
		s_axi_bready <= 1'b1;
		@(posedge clk_sys);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axWrite

	// read: address held until taken, data taken with rvalid
	task automatic axRead(input bgp_addr_type a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge clk_sys);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axRead

	// write expecting an okay answer
	task automatic wr(input bgp_addr_type a, input bgp_byte_type d);
		axWrite(a, d, rsp);
		`CHK("write resp", `BGP_RESP_OKAY, rsp)
	endtask : wr

	// read expecting an okay answer and the given byte
	task automatic rdChk(input string nm, input bgp_addr_type a, input bgp_byte_type ex);
		axRead(a, rd, rsp);
		`CHK(nm, {24'h000000, ex}, rd)
		`CHK("read resp", `BGP_RESP_OKAY, rsp)
	endtask : rdChk

	task automatic testDone(input string nm);
		$display("test %s done", nm);
	endtask : testDone

	// ------------------------------------------------
	// verdict
	// ------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", totalChecks, errors);
		if (errors == 0 && totalChecks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	// watchdog well beyond the roughly 130 cycles of the run
	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		conclude();
	end

	// ------------------------------------------------
	// tests
	// ------------------------------------------------
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		// reset state and plain input reads
		`CHK("third oe", 8'hFF, thirdOe_n)
		`CHK("fourth oe", 8'hFF, fourthOe_n)
		rdChk("third dir", `BGP_THIRD_DIR_OFF, 8'hFF);
		rdChk("fourth dir", `BGP_FOURTH_DIR_OFF, 8'hFF);
		rdChk("third pins", `BGP_THIRD_DATA_OFF, 8'hA5);
		testDone("reset");
		// pins pass two flops: first read still sees the old level
		@(posedge clk_sys);
		extThird <= 8'h3A;
		rdChk("sync old", `BGP_THIRD_DATA_OFF, 8'hA5);
		rdChk("sync new", `BGP_THIRD_DATA_OFF, 8'h3A);
		extThird <= 8'hA5;
		testDone("sync");
		// mixed direction: read returns pads, not latch
		wr(`BGP_THIRD_DATA_OFF, 8'h5A);
		wr(`BGP_THIRD_DIR_OFF, 8'h0F);
		`CHK("third oe mix", 8'h0F, thirdOe_n)
		`CHK("third latch", 8'h5A, thirdOut)
		rdChk("third mix", `BGP_THIRD_DATA_OFF, 8'h55);
		testDone("direction");
		// bit set and clear merge into pad levels, not latch
		wr(`BGP_THIRD_SET_OFF, 8'h01);
		`CHK("rmw set", 8'h55, thirdOut)
		wr(`BGP_THIRD_CLR_OFF, 8'h40);
		`CHK("rmw clear", 8'h15, thirdOut)
		testDone("rmw");
		// analog pins read zero but keep driving
		wr(`BGP_THIRD_ANALOG_OFF, 8'hF0);
		rdChk("analog read", `BGP_THIRD_DATA_OFF, 8'h05);
		`CHK("analog oe", 8'h0F, thirdOe_n)
		`CHK("analog drive", 8'h15, thirdOut)
		wr(`BGP_THIRD_DIR_OFF, 8'hFF);
		wr(`BGP_THIRD_ANALOG_OFF, 8'h00);
		testDone("analog");
		// low-power crystal mode forces low direction reads only
		wr(`BGP_THIRD_DIR_OFF, 8'hFC);
		wr(`BGP_CONTROL_OFF, 8'h01);
		rdChk("lp dir", `BGP_THIRD_DIR_OFF, 8'hFF);
		`CHK("lp oe", 8'hFC, thirdOe_n)
		wr(`BGP_CONTROL_OFF, 8'h00);
		rdChk("lp off dir", `BGP_THIRD_DIR_OFF, 8'hFC);
		testDone("lowpower");
		// fourth port fully output, then soft reset
		wr(`BGP_FOURTH_DATA_OFF, 8'hC3);
		wr(`BGP_FOURTH_DIR_OFF, 8'h00);
		`CHK("fourth out", 8'hC3, fourthOut)
		rdChk("fourth pins", `BGP_FOURTH_DATA_OFF, 8'hC3);
		wr(`BGP_FOURTH_DATA_OFF, 8'h96);
		`CHK("fourth load", 8'h96, fourthOut)
		wr(`BGP_FOURTH_SET_OFF, 8'h0C);
		`CHK("fourth set", 8'h9E, fourthOut)
		wr(`BGP_CONTROL_OFF, 8'h02);
		`CHK("srst oe", 8'hFF, fourthOe_n)
		`CHK("srst latch", 8'h9E, fourthOut)
		rdChk("srst dir", `BGP_THIRD_DIR_OFF, 8'hFF);
		testDone("softreset");
		// unmapped place refuses; lane-off write and set-place read answer okay
		axRead(8'h40, rd, rsp);
		`CHK("bad rd resp", `BGP_RESP_SLVERR, rsp)
		`CHK("bad rd data", 32'h00000000, rd)
		axWrite(8'h40, 8'hFF, rsp);
		`CHK("bad wr resp", `BGP_RESP_SLVERR, rsp)
		s_axi_wstrb <= 4'h0;
		wr(`BGP_THIRD_DATA_OFF, 8'hFF);
		s_axi_wstrb <= 4'hF;
		`CHK("lane off", 8'h15, thirdOut)
		rdChk("set reads zero", `BGP_THIRD_SET_OFF, 8'h00);
		testDone("unmapped");
		conclude();
	end
endmodule : bgp_top_tb_top

`default_nettype wire
